// >>> src/cirr_pkg.sv
// Package holding constants and types of the card identity and resource readout block
package cirr_pkg;
    // Identifier layout
    localparam int ID_BYTES = 9;
    localparam int ID_BITS = 72;
    localparam int ID_BIT_IDX_W = 7;
    localparam logic [6:0] ID_LAST_BIT = 7'h47;
    // Letter code range
    localparam logic [4:0] LETTER_MIN = 5'h01;
    localparam logic [4:0] LETTER_MAX = 5'h1A;
    // Serial number when card has no unique numbering
    localparam logic [31:0] SERIAL_NONE = 32'hFFFFFFFF;
    // Resource item tag fields
    localparam int TAG_TYPE_BIT = 7;
    localparam int TAG_NAME_HI = 6;
    localparam int TAG_NAME_LO = 3;
    localparam int TAG_LEN_HI = 2;
    localparam int TAG_LEN_LO = 0;
    localparam logic [3:0] SMALL_VERSION = 4'h1;
    localparam logic [3:0] SMALL_END = 4'hF;
    // Resource store
    localparam int RES_DEPTH = 32;
    localparam int RES_IDX_W = 5;
    // Status bit position of the byte-ready flag
    localparam int STAT_READY_BIT = 0;
    // Reset base and span of the decoded I/O window
    localparam logic [15:0] IO_BASE_RESET = 16'h0000;
    localparam logic [15:0] IO_SPAN = 16'h0008;
    // Fill pipeline states
    typedef enum logic [2:0] {
        FILL_IDLE = 3'b001,
        FILL_PUSH = 3'b010,
        FILL_DONE = 3'b100
    } cirr_fill_type;
endpackage

// >>> src/cirr_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module cirr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4,
    parameter int AW = 2
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    input wire logic flush
);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] wr_next;
    logic [AW-1:0] rd_reg;
    logic [AW-1:0] rd_next;
    logic [AW:0] cnt_reg;
    logic [AW:0] cnt_next;
    logic push;
    logic pop;

    // Honest flags from the occupancy count, both forced low while flush is high
    assign in_ready = (cnt_reg != (AW+1)'(DEPTH)) && !flush;
    assign out_valid = (cnt_reg != '0) && !flush;
    assign out_data = mem_reg[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Next pointers, count and storage
    always_comb begin
        mem_next = mem_reg;
        wr_next = wr_reg;
        rd_next = rd_reg;
        cnt_next = cnt_reg;
        if (flush) begin
            wr_next = '0;
            rd_next = '0;
            cnt_next = '0;
        end else begin
            if (push) begin
                mem_next[wr_reg] = in_data;
                wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + AW'(1);
            end
            if (pop) begin
                rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + AW'(1);
            end
            cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Register stage
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            mem_reg <= mem_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule // cirr_fifo

// >>> src/cirr_top.sv
// Card-side identity and resource data readout with activation-gated decode
// What this block does
// - Configuration reads are allowed anytime and never disturb card functions.
// - Configuration registers are readable and writable (base writes ignored on fixed-resource devices); base reads back its programmed value.
// - Device decodes only assigned resources; adopts new settings on activation.
// - Activation readback reports the real active state, not the written value.
// - Fixed-resource devices still honour activation to leave the bus.
// - Identity is returned one bit per isolation port read.
// - Resource data advances by one byte per data port read.
// - Identifier is four code bytes, four serial bytes low first, checksum.
// - Code byte 0 bit7 clear, letter1 in 6:2, letter2 high bits 1:0.
// - Code bytes 2-3 carry three product digits and revision, upper nibble first.
// - Letters use five bits, A is 00001 through Z is 11010.
// - Serial unique per code; without unique numbering it reads all ones.
// - Resource data is tagged items; first byte bit 7 picks short or long.
// - Resource data contains version, text identifier and every fixed resource.
// - Order is version, identifier, per device items, then end tag.
// - Descriptor order binds to registers; null fillers keep mapping stable.
// - Short item is 2 to 8 bytes; tag has name 6:3, length 2:0.
// - Byte ready sets status bit 0; data read clears it until next byte.
`timescale 1ns/1ps
module cirr_top
    import cirr_pkg::*;
#(
    parameter logic [4:0] LETTER1 = 5'h01,       // Arbitrary maker letters
    parameter logic [4:0] LETTER2 = 5'h02,
    parameter logic [4:0] LETTER3 = 5'h03,
    parameter logic [11:0] PRODUCT = 12'h123,    // Arbitrary product number
    parameter logic [3:0] REVISION = 4'h0,       // Arbitrary revision
    parameter logic UNIQUE_SERIAL = 1'b0,
    parameter logic [31:0] SERIAL = 32'h00000001, // Arbitrary serial value
    parameter logic [7:0] CHECKSUM = 8'h00,      // Supplied by the card builder
    parameter int FIFO_DEPTH = 4,
    parameter int FIFO_AW = 2,
    parameter logic [8*RES_DEPTH-1:0] RES_IMAGE = {
        {28{8'h00}}, 8'h79, 8'h00, 8'h10, 8'h0A}, // Version item then end tag
    parameter logic [RES_IDX_W-1:0] RES_LEN = 5'h05
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cfg_enter,
    input wire logic iso_read,
    output logic iso_bit,
    input wire logic res_read,
    output logic [7:0] res_data,
    output logic res_ready,
    input wire logic act_wr,
    input wire logic act_wdata,
    output logic act_status,
    input wire logic io_base_wr,
    input wire logic [15:0] io_base_wdata,
    output logic [15:0] io_base_rdata,
    input wire logic fixed_resources,
    input wire logic func_busy,
    input wire logic [15:0] bus_addr,
    input wire logic bus_cycle,
    output logic dev_select
);
    // Identity bits, least significant byte first on the wire
    logic [ID_BITS-1:0] ident;
    logic [7:0] code_b0;
    logic [7:0] code_b1;
    logic [7:0] code_b2;
    logic [7:0] code_b3;
    logic letters_ok;
    logic [31:0] serial_val;
    logic [ID_BIT_IDX_W-1:0] id_idx_reg;
    logic [ID_BIT_IDX_W-1:0] id_idx_next;
    logic iso_bit_reg;
    logic iso_bit_next;
    // Resource pointer and fill FSM
    cirr_fill_type fill_reg;
    cirr_fill_type fill_next;
    logic [RES_IDX_W-1:0] ptr_reg;
    logic [RES_IDX_W-1:0] ptr_next;
    logic [7:0] res_data_reg;
    logic [7:0] res_data_next;
    logic ready_reg;
    logic ready_next;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [7:0] fifo_out_data;
    logic [7:0] cur_byte;
    // Configuration registers
    logic act_req_reg;
    logic act_req_next;
    logic act_live_reg;
    logic act_live_next;
    logic [15:0] io_prog_reg;
    logic [15:0] io_prog_next;
    logic [15:0] io_live_reg;
    logic [15:0] io_live_next;

    // Reads one byte from the constant resource image
    // Bytes beyond the image length are never fetched
    function automatic logic [7:0] res_byte(input logic [RES_IDX_W-1:0] idx);
        res_byte = RES_IMAGE[8*idx +: 8];
    endfunction

    // Checks a letter sits in the A..Z code range
    function automatic logic letter_ok(input logic [4:0] l);
        letter_ok = (l >= LETTER_MIN) && (l <= LETTER_MAX);
    endfunction

    // True when an address falls in the span above a base; the sum is one bit
    // wider so a base near the top of I/O space cannot wrap around
    function automatic logic in_window(input logic [15:0] addr, input logic [15:0] base);
        in_window = (addr >= base) && ({1'b0, addr} < ({1'b0, base} + {1'b0, IO_SPAN}));
    endfunction

    // Build identity bytes; a bad letter yields zero so faults show up early
    assign code_b0 = {1'b0, LETTER1, LETTER2[4:3]};
    assign code_b1 = {LETTER2[2:0], LETTER3};
    // Product digits go upper nibble first, and the revision digit sits below
    // the third product digit rather than above it
    assign code_b2 = PRODUCT[11:4];
    assign code_b3 = {PRODUCT[3:0], REVISION};
    assign serial_val = UNIQUE_SERIAL ? SERIAL : SERIAL_NONE;
    assign letters_ok = letter_ok(LETTER1) && letter_ok(LETTER2) && letter_ok(LETTER3);
    // Wire order is byte 0 first, so the first field sits at the bottom
    assign ident = letters_ok ? {
        CHECKSUM,
        serial_val[31:24],
        serial_val[23:16],
        serial_val[15:8],
        serial_val[7:0],
        code_b3,
        code_b2,
        code_b1,
        code_b0} : '0;

    // Isolation bit sequencer: one identity bit per isolation read. The index
    // wraps after the checksum, so a host that over-reads sees the identity
    // again; re-entering configuration wins over a read in the same cycle
    always_comb begin
        id_idx_next = id_idx_reg;
        iso_bit_next = iso_bit_reg;
        if (cfg_enter) begin
            id_idx_next = '0;
        end else if (iso_read) begin
            iso_bit_next = ident[id_idx_reg];
            id_idx_next = (id_idx_reg == ID_LAST_BIT) ? '0 : id_idx_reg + 7'h01;
        end
    end

    // Register stage of the isolation sequencer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            id_idx_reg <= '0;
            iso_bit_reg <= 1'b0;
        end else begin
            id_idx_reg <= id_idx_next;
            iso_bit_reg <= iso_bit_next;
        end
    end

    // Bit stands until the next isolation read
    assign iso_bit = iso_bit_reg;

    // Prefetch the image into the FIFO so a data read never waits on storage
    assign cur_byte = res_byte(ptr_reg);
    assign fifo_in_valid = (fill_reg == FILL_PUSH);
    assign fifo_out_ready = !ready_reg || res_read;

    // Image walk: one byte pushed per free slot; the walk stops at the last
    // byte, so reads past the end just leave the ready flag low
    always_comb begin
        fill_next = fill_reg;
        ptr_next = ptr_reg;
        case (fill_reg)
            FILL_IDLE: begin
                fill_next = FILL_PUSH;
            end
            FILL_PUSH: begin
                if (fifo_in_ready) begin
                    // Bytes advance only while the FIFO has a free slot, so a full FIFO stalls the walk until reads drain it
                    if (ptr_reg == RES_LEN - 5'h01) begin
                        fill_next = FILL_DONE;
                    end else begin
                        ptr_next = ptr_reg + 5'h01;
                    end
                end
            end
            FILL_DONE: begin
                fill_next = FILL_DONE;
            end
            default: begin
                fill_next = FILL_IDLE;
            end
        endcase
        if (cfg_enter) begin
            fill_next = FILL_IDLE;
            ptr_next = '0;
        end
    end

    // Output byte and ready flag; a fresh byte loaded in the read cycle wins
    // The reload beats the read clear, which is the set-wins case of the flag
    always_comb begin
        res_data_next = res_data_reg;
        ready_next = ready_reg;
        if (res_read) begin
            ready_next = 1'b0;
        end
        if (fifo_out_valid && fifo_out_ready) begin
            res_data_next = fifo_out_data;
            ready_next = 1'b1;
        end
        if (cfg_enter) begin
            ready_next = 1'b0;
        end
    end

    // Register stage of the resource walk and output byte
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fill_reg <= FILL_IDLE;
            ptr_reg <= '0;
            res_data_reg <= 8'h00;
            ready_reg <= 1'b0;
        end else begin
            fill_reg <= fill_next;
            ptr_reg <= ptr_next;
            res_data_reg <= res_data_next;
            ready_reg <= ready_next;
        end
    end

    // Data and flag come straight from flops, so the host never sees a glitch
    assign res_data = res_data_reg;
    assign res_ready = ready_reg;

    // Byte FIFO between image walk and data port
    // Four bytes cover the turn-around of the host's poll and read
    cirr_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(cur_byte),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .flush(cfg_enter)
    );

    // A base written while active stays unused until the next activation, so
    // a host that skips the deactivate step keeps the old decode window
    // Activation and base registers; the live base changes only on activation, live state also on deactivate
    always_comb begin
        act_req_next = act_req_reg;
        io_prog_next = io_prog_reg;
        io_live_next = io_live_reg;
        act_live_next = act_live_reg;
        if (act_wr) begin
            act_req_next = act_wdata;
        end
        if (io_base_wr && !fixed_resources) begin
            io_prog_next = io_base_wdata;
        end
        // Live state falls at once on deactivate but rises only when the
        // function is idle, so readback can lag the written value
        if (!act_req_reg) begin
            act_live_next = 1'b0;
        end else if (!act_live_reg && !func_busy) begin
            act_live_next = 1'b1;
            io_live_next = io_prog_reg;
        end
    end

    // Register stage of the activation state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            act_req_reg <= 1'b0;
            act_live_reg <= 1'b0;
            io_prog_reg <= IO_BASE_RESET;
            io_live_reg <= IO_BASE_RESET;
        end else begin
            act_req_reg <= act_req_next;
            act_live_reg <= act_live_next;
            io_prog_reg <= io_prog_next;
            io_live_reg <= io_live_next;
        end
    end

    assign act_status = act_live_reg;
    assign io_base_rdata = io_prog_reg;

    // Decode only the assigned window, and only while really active; a zero
    // base means no I/O range was assigned
    assign dev_select = bus_cycle && act_live_reg && (io_live_reg != 16'h0000) &&
        in_window(bus_addr, io_live_reg);
endmodule // cirr_top

// >>> testbench/cirr_top_props.sv
// Concurrent checks on the ports of the identity and resource readout block
`timescale 1ns/1ps
module cirr_top_props (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cfg_enter,
    input wire logic iso_read,
    input wire logic iso_bit,
    input wire logic res_read,
    input wire logic [7:0] res_data,
    input wire logic res_ready,
    input wire logic act_wr,
    input wire logic act_wdata,
    input wire logic act_status,
    input wire logic io_base_wr,
    input wire logic [15:0] io_base_wdata,
    input wire logic [15:0] io_base_rdata,
    input wire logic fixed_resources,
    input wire logic func_busy,
    input wire logic [15:0] bus_addr,
    input wire logic bus_cycle,
    input wire logic dev_select
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_iso_hold: assert property (!iso_read && !cfg_enter |=> $stable(iso_bit))
        else $error("identity bit moved without a read");
    a_byte_hold: assert property (res_ready && !res_read && !cfg_enter |=>
        res_ready && $stable(res_data))
        else $error("resource byte changed without a read");
    a_ready_cause: assert property ($fell(res_ready) |->
        $past(res_read) || $past(cfg_enter))
        else $error("ready flag dropped without a read");
    // Window of one cycle on the status update keeps the pipeline depth open
    a_act_rise: assert property (act_wr && act_wdata && !func_busy ##1
        (!act_wr && !func_busy)[*2] |-> ##[0:1] act_status)
        else $error("activation did not take effect");
    a_act_fall: assert property (act_wr && !act_wdata ##1 !act_wr[*2] |->
        ##[0:1] !act_status)
        else $error("deactivation did not take effect");
    a_act_defer: assert property (!act_status && act_wr && act_wdata && func_busy ##1
        func_busy[*3] |-> !act_status)
        else $error("status claims active while function is busy");
    a_base_back: assert property (io_base_wr && !fixed_resources |=>
        io_base_rdata == $past(io_base_wdata))
        else $error("programmed base not read back");
    a_sel_active: assert property (dev_select |-> act_status && bus_cycle)
        else $error("decode while inactive or idle");
endmodule // cirr_top_props

bind cirr_top cirr_top_props u_props (
    .sys_clk(sys_clk), .rst(rst), .cfg_enter(cfg_enter), .iso_read(iso_read),
    .iso_bit(iso_bit), .res_read(res_read), .res_data(res_data), .res_ready(res_ready),
    .act_wr(act_wr), .act_wdata(act_wdata), .act_status(act_status),
    .io_base_wr(io_base_wr), .io_base_wdata(io_base_wdata), .io_base_rdata(io_base_rdata),
    .fixed_resources(fixed_resources), .func_busy(func_busy), .bus_addr(bus_addr),
    .bus_cycle(bus_cycle), .dev_select(dev_select)
);

// >>> testbench/cirr_host.sv
// Host software model that polls the ready flag and reads resource bytes
`timescale 1ns/1ps
module cirr_host (
    input wire logic sys_clk,
    input wire logic go,
    input wire logic stall,
    input wire logic res_ready,
    input wire logic [7:0] res_data,
    output logic res_read,
    output logic [7:0] rd_byte
);
    // Read strobe starts idle so the first poll sees a known level
    logic rd_q = 1'b0;

    assign res_read = rd_q;

    // One read per poll; stall lets the host be slow so the buffer fills up
    always @(negedge sys_clk) begin
        if (rd_q) begin
            rd_q <= 1'b0;
        end else if (go && !stall && res_ready) begin
            rd_q <= 1'b1;
            rd_byte <= res_data;
        end
    end
endmodule // cirr_host

// >>> testbench/cirr_top_tb.sv
// Self-checking testbench of the identity and resource readout block
`timescale 1ns/1ps
module cirr_top_tb;
    import cirr_pkg::*;
    localparam logic [4:0] L1 = 5'h0E;
    localparam logic [4:0] L2 = 5'h1A;
    localparam logic [4:0] L3 = 5'h01;
    localparam logic [11:0] PROD = 12'hA5C;
    localparam logic [7:0] IMG [5] = '{{1'b0, 4'h1, 3'h2}, 8'h10, 8'h00,
        {1'b0, 4'hF, 3'h1}, 8'h00};
    logic sys_clk = 0, rst = 1, cfg_enter = 0, iso_read = 0, iso_bit, res_read, res_ready;
    logic act_wr = 0, act_wdata = 0, act_status, io_base_wr = 0, fixed_resources = 0;
    logic func_busy = 0, bus_cycle = 0, dev_select, go = 0, stall = 0;
    logic [7:0] res_data, rd_byte;
    logic [15:0] io_base_wdata = 16'h0000, io_base_rdata, bus_addr = 16'h0000;
    logic [15:0] base = 16'h0000, prev = 16'h0000;
    logic [71:0] id_exp;
    logic [7:0] got [$];
    int error_cnt = 0, n_compared = 0;

    cirr_top #(.LETTER1(L1), .LETTER2(L2), .LETTER3(L3), .PRODUCT(PROD), .REVISION(4'h7),
        .UNIQUE_SERIAL(1'b0), .SERIAL(32'h13572468), .CHECKSUM(8'h5C)) dut (
        .sys_clk(sys_clk), .rst(rst), .cfg_enter(cfg_enter), .iso_read(iso_read),
        .iso_bit(iso_bit), .res_read(res_read), .res_data(res_data), .res_ready(res_ready),
        .act_wr(act_wr), .act_wdata(act_wdata), .act_status(act_status),
        .io_base_wr(io_base_wr), .io_base_wdata(io_base_wdata), .io_base_rdata(io_base_rdata),
        .fixed_resources(fixed_resources), .func_busy(func_busy), .bus_addr(bus_addr),
        .bus_cycle(bus_cycle), .dev_select(dev_select));

    cirr_host host (.sys_clk(sys_clk), .go(go), .stall(stall), .res_ready(res_ready),
        .res_data(res_data), .res_read(res_read), .rd_byte(rd_byte));

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    // Bytes taken by the host, captured at the edge that sees the read
    always @(posedge sys_clk) begin
        if (res_read) got.push_back(rd_byte);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("Compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Identity with serial field all ones, since this card has no unique numbering
    function automatic logic [71:0] id_model();
        return {8'h5C, 32'hFFFFFFFF, PROD[3:0], 4'h7, PROD[11:4],
            L2[2:0], L3, 1'b0, L1, L2[4:3]};
    endfunction

    function automatic logic exp_sel(input logic [15:0] a, input logic [15:0] b,
        input logic act, input logic cyc);
        return cyc && act && b != 16'h0000 && a >= b && {1'b0, a} < {1'b0, b} + 17'h00008;
    endfunction

    task automatic enter();
        cfg_enter = 1;
        @(negedge sys_clk);
        cfg_enter = 0;
        @(negedge sys_clk);
    endtask

    // Status is looked at three cycles on, covering either pipeline depth
    task automatic act(input logic v);
        act_wr = 1;
        act_wdata = v;
        @(negedge sys_clk);
        act_wr = 0;
        repeat (3) @(negedge sys_clk);
    endtask

    task automatic wbase(input logic [15:0] b);
        io_base_wr = 1;
        io_base_wdata = b;
        @(negedge sys_clk);
        io_base_wr = 0;
        @(negedge sys_clk);
    endtask

    // Addresses around the window edges, the last one at the old base
    task automatic sel_sweep(input logic [15:0] b, input logic a);
        for (int j = 0; j < 12; j++) begin
            bus_addr = (j == 11) ? prev : b - 16'h0004 + 16'($urandom % 16);
            bus_cycle = ($urandom % 4) != 0;
            #1;
            check(dev_select, exp_sel(bus_addr, b, a, bus_cycle), "decode");
            @(negedge sys_clk);
        end
        bus_cycle = 0;
    endtask

    task automatic read_id(input int n);
        for (int i = 0; i < n; i++) begin
            iso_read = 1;
            @(negedge sys_clk);
            iso_read = 0;
            repeat (1 + $urandom % 2) @(negedge sys_clk);
            check(iso_bit, id_exp[i % 72], "identity bit");
        end
    endtask

    task automatic read_res();
        got.delete();
        go <= 1'b1;
        for (int k = 0; k < 300 && got.size() < 5; k++) begin
            stall <= 1'($urandom % 2);
            @(negedge sys_clk);
        end
        stall <= 1'b0;
        repeat (20) @(negedge sys_clk);
        go <= 1'b0;
        check(got.size(), 5, "byte count");
        check(res_ready, 0, "ready past end");
        for (int k = 0; k < 5; k++) check(got[k], IMG[k], "resource byte");
    endtask

    initial begin
        #100000;
        error_cnt++;
        $display("BAD %0t watchdog expired", $time);
        end_sim();
    end

    initial begin
        void'($urandom(32'hAB31));
        id_exp = id_model();
        repeat (12) @(negedge sys_clk);
        rst = 0;
        @(negedge sys_clk);
        for (int i = 0; i < 4; i++) begin
            act(0);
            check(act_status, 0, "deactivated");
            prev = base;
            base = 16'h0100 + 16'($urandom % 32'hF000);
            wbase(base);
            check(io_base_rdata, base, "base readback");
            func_busy = (i == 1);
            act(1);
            check(act_status, !func_busy, "activation status");
            func_busy = 0;
            repeat (4) @(negedge sys_clk);
            check(act_status, 1, "activated");
            sel_sweep(base, 1);
        end
        $display("Test activation done");
        enter();
        read_id(80);
        enter();
        read_id(4);
        $display("Test identity done");
        read_res();
        enter();
        read_res();
        $display("Test resource data done");
        check(act_status, 1, "status after reads");
        check(io_base_rdata, base, "base after reads");
        fixed_resources = 1;
        act(0);
        wbase(base ^ 16'h0F00);
        check(io_base_rdata, base, "fixed base kept");
        sel_sweep(base, 0);
        act(1);
        sel_sweep(base, 1);
        $display("Test fixed device done");
        end_sim();
    end
endmodule // cirr_top_tb
